// ==== hw/ccsc_top.v ====
// Clock gen settle control: link clock gate and divider, CPU clock
// divider, PLL settle hold and oscillator settle watch after standby.
// Assumes core_clk stands in for both the PLL output and the external
// clock; the CPU gives a one-cycle sleep pulse on the same clock.
`include "ccsc_consts.vh"
`timescale 1ns/1ns
`default_nettype none

// ************************************************
// Divider: one-cycle tick every ratio cycles
// ************************************************
module ccsc_div (
   // Clock and reset
   input  wire       core_clk,
   input  wire       rst,
   // Control
   input  wire       run,
   input  wire [4:0] ratio,
   // Tick
   output reg        tick
);
   reg [4:0] cnt_reg;
   reg [4:0] last_reg;

   // New ratio restarts the count, so it applies at once
   always @(posedge core_clk) begin
      last_reg <= ratio;
      if (rst || !run) begin
         cnt_reg <= 5'h00;
         tick    <= 1'b0;
      end else if (ratio != last_reg) begin
         cnt_reg <= 5'h00;
         tick    <= 1'b0;
      end else if (cnt_reg >= ratio - 5'h01) begin
         cnt_reg <= 5'h00;
         tick    <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 5'h01;
         tick    <= 1'b0;
      end
   end
endmodule // ccsc_div

// ************************************************
// Top
// ************************************************
module ccsc_top #(
   parameter CLK_MHZ = 10,
   parameter PLL_SET_CYC = (`CCSC_PLL_SET_NS * CLK_MHZ) / 1000
) (
   // Clock and reset
   input  wire        core_clk,
   input  wire        rst,
   // Wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // Pins and CPU
   input  wire        clockModePinLow,
   input  wire        clockModePinHigh,
   input  wire        nmiPin,
   input  wire        sleepReq,
   // Clock side
   output reg         linkClkTick,
   output reg         cpuClkTick,
   output reg         cpuHold,
   output reg         clkStopped,
   output reg         oscStopped,
   output reg         pllEnabled
);
   // States, one-hot
   localparam ST_RUN    = 3'b001;
   localparam ST_STANDBY_SELECT   = 3'b010;
   localparam ST_SETTLE = 3'b100;

   // Register fields
   reg [4:0]  pllMultiplier_reg;
   reg [3:0]  cpuDiv_reg;
   reg        pllOn_reg;
   reg        linkHalt_reg;
   reg [3:0]  linkDiv_reg;
   reg [7:0]  settleStart_reg;
   reg        settleWait_reg;
   reg        oscStopInStandby_reg;
   reg [2:0]  countClockSelect_reg;
   reg        standbySelect_reg;

   // Sync, state and counters
   reg [1:0]  mode1_reg;
   reg [1:0]  mode2_reg;
   reg        nmi1_reg;
   reg        nmi2_reg;
   reg        nmi3_reg;
   reg [2:0]  state_reg;
   reg [7:0]  settleCnt_reg;
   reg [11:0] presc_reg;
   reg [15:0] pllCnt_reg;

   wire [4:0] linkRatio;
   wire [4:0] cpuRatio;
   wire       linkTickW;
   wire       cpuTickW;
   wire       access;
   wire       wrOk;
   wire       nmiEdge;
   wire       prescTick;
   wire [11:0] prescMask;
   reg  [31:0] rd_next;

   // ************************************************
   // Code decoding
   // ************************************************
   // Zero marks a prohibited code
   function [4:0] divRatio;
      input [3:0] code;
      begin
         case (code)
            4'h0: divRatio = 5'h01;
            4'h2: divRatio = 5'h02;
            4'h4: divRatio = 5'h03;
            4'h5: divRatio = 5'h04;
            4'h7: divRatio = 5'h06;
            4'h8: divRatio = 5'h08;
            4'h9: divRatio = 5'h0A;
            4'hA: divRatio = 5'h0C;
            4'hB: divRatio = 5'h10;
            4'hC: divRatio = 5'h14;
            default: divRatio = 5'h00;
         endcase
      end
   endfunction

   // Multiplier is code plus one; only x2,3,4,6,8,16 legal
   function multOk;
      input [4:0] code;
      begin
         case (code)
            5'h01, 5'h02, 5'h03, 5'h05, 5'h07, 5'h0F: multOk = 1'b1;
            default: multOk = 1'b0;
         endcase
      end
   endfunction

   // Prescale mask selects EXT/1 up to EXT/4096
   function [11:0] cksMask;
      input [2:0] sel;
      begin
         case (sel)
            3'h0: cksMask = 12'h000;
            3'h1: cksMask = 12'h003;
            3'h2: cksMask = 12'h00F;
            3'h3: cksMask = 12'h01F;
            3'h4: cksMask = 12'h03F;
            3'h5: cksMask = 12'h0FF;
            3'h6: cksMask = 12'h3FF;
            default: cksMask = 12'hFFF;
         endcase
      end
   endfunction

   assign linkRatio = divRatio(linkDiv_reg);
   assign cpuRatio  = divRatio(cpuDiv_reg);
   assign prescMask = cksMask(countClockSelect_reg);
   assign prescTick = ((presc_reg & prescMask) == prescMask);
   assign nmiEdge   = nmi2_reg & ~nmi3_reg;

   // Only full-word writes land; narrow ones are acked and dropped
   assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wrOk   = access & wb_we_i & (wb_sel_i == 4'hF);

   // ************************************************
   // Pin synchronisers
   // ************************************************
   // Two stages; the mode pins use the second, the NMI edge compares the second with a third
   always @(posedge core_clk) begin
      mode1_reg <= {clockModePinHigh, clockModePinLow};
      mode2_reg <= mode1_reg;
      nmi1_reg  <= nmiPin;
      nmi2_reg  <= nmi1_reg;
      nmi3_reg  <= nmi2_reg;
   end

   // ************************************************
   // Register writes
   // ************************************************
   // Mode pins are looked at only under reset
   always @(posedge core_clk) begin
      if (rst) begin
         pllMultiplier_reg    <= `CCSC_MULT_RST;
         pllOn_reg            <= (mode2_reg != `CCSC_MODE_NOPLL);
         cpuDiv_reg           <= (mode2_reg == `CCSC_MODE_NOPLL) ?
                                 `CCSC_CDIV_RST_B : `CCSC_CDIV_RST_A;
         linkHalt_reg         <= 1'b1;
         linkDiv_reg          <= `CCSC_LDIV_RST;
         settleStart_reg      <= `CCSC_START_RST;
         settleWait_reg       <= 1'b0;
         oscStopInStandby_reg <= 1'b0;
         countClockSelect_reg <= 3'h0;
         standbySelect_reg    <= 1'b0;
      end else if (wrOk) begin
         case (wb_adr_i)
            `CCSC_OFS_FREQ: begin
               // Illegal codes keep the old setting
               if (multOk(wb_dat_i[`CCSC_MULT_HI:`CCSC_MULT_LO]))
                  pllMultiplier_reg <= wb_dat_i[`CCSC_MULT_HI:`CCSC_MULT_LO];
               if (divRatio(wb_dat_i[`CCSC_CDIV_HI:`CCSC_CDIV_LO]) != 5'h00)
                  cpuDiv_reg <= wb_dat_i[`CCSC_CDIV_HI:`CCSC_CDIV_LO];
            end
            `CCSC_OFS_PLL:
               pllOn_reg <= wb_dat_i[`CCSC_PLLON_BIT];
            `CCSC_OFS_LINK: begin
               linkHalt_reg <= wb_dat_i[`CCSC_HALT_BIT];
               if (divRatio(wb_dat_i[`CCSC_LDIV_HI:`CCSC_LDIV_LO]) != 5'h00)
                  linkDiv_reg <= wb_dat_i[`CCSC_LDIV_HI:`CCSC_LDIV_LO];
            end
            `CCSC_OFS_SETTLE: begin
               settleStart_reg      <= wb_dat_i[`CCSC_START_HI:`CCSC_START_LO];
               settleWait_reg       <= wb_dat_i[`CCSC_WAIT_BIT];
               oscStopInStandby_reg <= wb_dat_i[`CCSC_OSTOP_BIT];
               countClockSelect_reg <= wb_dat_i[`CCSC_CKS_HI:`CCSC_CKS_LO];
            end
            `CCSC_OFS_STANDBY_SELECT:
               standbySelect_reg <= wb_dat_i[`CCSC_SSEL_BIT];
            default: ;
         endcase
      end
   end

   // ************************************************
   // Register reads
   // ************************************************
   // Reserved bits and unmapped offsets read zero
   always @* begin
      rd_next = 32'h0000_0000;
      case (wb_adr_i)
         `CCSC_OFS_FREQ: begin
            rd_next[`CCSC_MULT_HI:`CCSC_MULT_LO] = pllMultiplier_reg;
            rd_next[`CCSC_CDIV_HI:`CCSC_CDIV_LO] = cpuDiv_reg;
         end
         `CCSC_OFS_PLL:
            rd_next[`CCSC_PLLON_BIT] = pllOn_reg;
         `CCSC_OFS_LINK: begin
            rd_next[`CCSC_HALT_BIT] = linkHalt_reg;
            rd_next[`CCSC_LDIV_HI:`CCSC_LDIV_LO] = linkDiv_reg;
         end
         `CCSC_OFS_SETTLE: begin
            // Start value reads back, not the live count
            rd_next[`CCSC_START_HI:`CCSC_START_LO] = settleStart_reg;
            rd_next[`CCSC_WAIT_BIT]  = settleWait_reg;
            rd_next[`CCSC_OSTOP_BIT] = oscStopInStandby_reg;
            rd_next[`CCSC_CKS_HI:`CCSC_CKS_LO] = countClockSelect_reg;
         end
         `CCSC_OFS_STANDBY_SELECT:
            rd_next[`CCSC_SSEL_BIT] = standbySelect_reg;
         default: rd_next = 32'h0000_0000;
      endcase
   end

   // Ack one cycle after the strobe, dropped the cycle after
   always @(posedge core_clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= access;
         wb_dat_o <= access ? rd_next : 32'h0000_0000;
      end
   end

   // ************************************************
   // PLL settle hold
   // ************************************************
   // A real multiplier change or PLL toggle halts the CPU for the
   // settle time.
   always @(posedge core_clk) begin
      if (rst) begin
         pllCnt_reg <= 16'h0000;
         cpuHold    <= 1'b0;
      end else if (wrOk && (wb_adr_i == `CCSC_OFS_FREQ) &&
                   multOk(wb_dat_i[`CCSC_MULT_HI:`CCSC_MULT_LO]) &&
                   (wb_dat_i[`CCSC_MULT_HI:`CCSC_MULT_LO] != pllMultiplier_reg)) begin
         pllCnt_reg <= PLL_SET_CYC[15:0];
         cpuHold    <= 1'b1;
      end else if (wrOk && (wb_adr_i == `CCSC_OFS_PLL) &&
                   (wb_dat_i[`CCSC_PLLON_BIT] != pllOn_reg)) begin
         pllCnt_reg <= PLL_SET_CYC[15:0];
         cpuHold    <= 1'b1;
      end else if (pllCnt_reg > 16'h0001) begin
         pllCnt_reg <= pllCnt_reg - 16'h0001;
      end else begin
         pllCnt_reg <= 16'h0000;
         cpuHold    <= 1'b0;
      end
   end

   // ************************************************
   // Standby and settle watch
   // ************************************************
   // Counter runs only after an NMI edge with a stopped oscillator
   always @(posedge core_clk) begin
      if (rst) begin
         state_reg     <= ST_RUN;
         clkStopped    <= 1'b0;
         oscStopped    <= 1'b0;
         settleCnt_reg <= 8'h00;
         presc_reg     <= 12'h000;
      end else begin
         case (state_reg)
            ST_RUN: begin
               presc_reg <= 12'h000;
               if (sleepReq && standbySelect_reg && !cpuHold) begin
                  state_reg  <= ST_STANDBY_SELECT;
                  clkStopped <= 1'b1;
                  oscStopped <= oscStopInStandby_reg;
               end
            end
            ST_STANDBY_SELECT: begin
               if (nmiEdge) begin
                  if (settleWait_reg && oscStopped) begin
                     state_reg     <= ST_SETTLE;
                     settleCnt_reg <= settleStart_reg;
                     presc_reg     <= 12'h001;
                  end else begin
                     state_reg  <= ST_RUN;
                     clkStopped <= 1'b0;
                  end
                  oscStopped <= 1'b0;
               end
            end
            ST_SETTLE: begin
               presc_reg <= presc_reg + 12'h001;
               if (prescTick) begin
                  if (settleCnt_reg == `CCSC_COUNT_TOP) begin
                     state_reg  <= ST_RUN;
                     clkStopped <= 1'b0;
                  end else begin
                     settleCnt_reg <= settleCnt_reg + 8'h01;
                  end
               end
            end
            default: begin
               state_reg  <= ST_RUN;
               clkStopped <= 1'b0;
               oscStopped <= 1'b0;
            end
         endcase
      end
   end

   // ************************************************
   // Clock dividers
   // ************************************************
   // Link clock needs the PLL running and the halt bit clear
   ccsc_div u_linkDiv (
      .core_clk (core_clk),
      .rst      (rst),
      .run      (~linkHalt_reg & pllOn_reg & ~clkStopped),
      .ratio    (linkRatio),
      .tick     (linkTickW)
   );

   // CPU clock is gated by standby and by the PLL settle hold
   ccsc_div u_cpuDiv (
      .core_clk (core_clk),
      .rst      (rst),
      .run      (~clkStopped & ~cpuHold),
      .ratio    (cpuRatio),
      .tick     (cpuTickW)
   );

   // Output stage puts the link and CPU ticks and pllEnabled on flip-flops
   always @(posedge core_clk) begin
      if (rst) begin
         linkClkTick <= 1'b0;
         cpuClkTick  <= 1'b0;
         pllEnabled  <= 1'b0;
      end else begin
         linkClkTick <= linkTickW;
         cpuClkTick  <= cpuTickW;
         pllEnabled  <= pllOn_reg;
      end
   end
endmodule // ccsc_top
`default_nettype wire

// ==== hw/ccsc_consts.vh ====
// Constants of the clock gen settle control block.
// Assumes inclusion by bare name from hw/ccsc_top.v.
`ifndef CCSC_CONSTS_VH
`define CCSC_CONSTS_VH

// ************************************************
// Register byte offsets
// ************************************************
`define CCSC_OFS_FREQ    8'h00
`define CCSC_OFS_LINK    8'h18
`define CCSC_OFS_STANDBY_SELECT    8'h20
`define CCSC_OFS_PLL     8'h24
`define CCSC_OFS_SETTLE  8'h44

// ************************************************
// Field positions
// ************************************************
`define CCSC_MULT_HI     28
`define CCSC_MULT_LO     24
`define CCSC_CDIV_HI     23
`define CCSC_CDIV_LO     20
`define CCSC_PLLON_BIT   14
`define CCSC_HALT_BIT    7
`define CCSC_LDIV_HI     3
`define CCSC_LDIV_LO     0
`define CCSC_START_HI    15
`define CCSC_START_LO    8
`define CCSC_WAIT_BIT    5
`define CCSC_OSTOP_BIT   4
`define CCSC_CKS_HI      2
`define CCSC_CKS_LO      0
`define CCSC_SSEL_BIT    7

// ************************************************
// Reset values and limits
// ************************************************
`define CCSC_MULT_RST    5'h07
`define CCSC_CDIV_RST_A  4'h5
`define CCSC_CDIV_RST_B  4'h0
`define CCSC_MODE_NOPLL  2'h1
`define CCSC_LDIV_RST    4'h0
`define CCSC_START_RST   8'h00
`define CCSC_COUNT_TOP   8'hFF
`define CCSC_PLL_SET_NS  10000

`endif

// ==== sim/ccsc_top_sva.sv ====
// Checker for the clock gen settle control top ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module ccsc_sva #(
   parameter CLK_MHZ     = 10,
   parameter PLL_SET_CYC = 100
) (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        rst,
   // Register bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // Clock side
   input wire logic        sleepReq,
   input wire logic        linkClkTick,
   input wire logic        cpuClkTick,
   input wire logic        cpuHold,
   input wire logic        clkStopped,
   input wire logic        oscStopped,
   input wire logic        pllEnabled
);
   // Shadows of what software set, kept apart from the design's own state
   wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire logic wrOk = take && wb_we_i && (wb_sel_i == 4'hF);
   logic haltSh_reg;
   logic sbySh_reg;
   int   holdCnt_reg;

   // Shadow writes and hold length counter; counts cycles seen with the CPU held
   always @(posedge core_clk) begin
      if (rst) begin
         haltSh_reg <= 1'b1;
         sbySh_reg  <= 1'b0;
      end else if (wrOk && wb_adr_i == 8'h18) begin
         haltSh_reg <= wb_dat_i[7];
      end else if (wrOk && wb_adr_i == 8'h20) begin
         sbySh_reg <= wb_dat_i[7];
      end
      holdCnt_reg <= (cpuHold && !rst) ? holdCnt_reg + 1 : 0;
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_ack_answer: assert property (take |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_link_halted: assert property (haltSh_reg && $past(haltSh_reg) |=> !linkClkTick)
      else $error("link tick while halted");
   a_hold_length: assert property ($fell(cpuHold) |-> holdCnt_reg == PLL_SET_CYC)
      else $error("hold length wrong");
   a_hold_toggle: assert property (wrOk && wb_adr_i == 8'h24 && wb_dat_i[14] != pllEnabled
      |=> cpuHold)
      else $error("no hold on pll toggle");
   a_pll_copy: assert property (wrOk && wb_adr_i == 8'h24
      |-> ##2 pllEnabled == $past(wb_dat_i[14], 2))
      else $error("pll enable not following");
   a_hold_quiet: assert property (cpuHold && $past(cpuHold) && $past(cpuHold, 2)
      |-> !cpuClkTick)
      else $error("cpu tick while held");
   a_stop_quiet: assert property (clkStopped && $past(clkStopped) && $past(clkStopped, 2)
      |-> !linkClkTick && !cpuClkTick)
      else $error("tick while stopped");
   a_sleep_enter: assert property (sleepReq && sbySh_reg && !cpuHold && !clkStopped
      |=> clkStopped)
      else $error("standby not entered");
   a_osc_in_stop: assert property (oscStopped |-> clkStopped)
      else $error("oscillator stopped outside standby");
endmodule // ccsc_sva

bind ccsc_top ccsc_sva #(.CLK_MHZ(CLK_MHZ), .PLL_SET_CYC(PLL_SET_CYC)) u_sva (
   .core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleepReq(sleepReq),
   .linkClkTick(linkClkTick), .cpuClkTick(cpuClkTick), .cpuHold(cpuHold),
   .clkStopped(clkStopped), .oscStopped(oscStopped), .pllEnabled(pllEnabled));
`default_nettype wire

// ==== sim/ccsc_top_tb.sv ====
// Self-checking bench for the clock gen settle control top.
// Assumes the checker is bound in; drives all ports itself.
`timescale 1ns/1ns
`default_nettype none
module ccsc_top_tb;
   localparam int HOLD = 4;
   logic core_clk, rst, wbCyc, wbStb, wbWe, modeLow, nmi, sleep, wbAck;
   logic [7:0]  wbAdr;
   logic [3:0]  wbSel;
   logic [31:0] wbDatI, wbDatO;
   logic linkTick, cpuTick, cpuHold, clkStop, oscStop, pllOn;
   logic [32:0] expQ[$];
   logic [32:0] note;
   logic [15:0] rnd;
   int errorCnt, samplesChecked, n, lo;
   int ratio[10] = '{1, 2, 3, 4, 6, 8, 10, 12, 16, 20};
   int pre[8] = '{1, 4, 16, 32, 64, 256, 1024, 4096};
   logic [3:0] code[10] = '{4'h0, 4'h2, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC};
   wire logic [1:0] ticks = {cpuTick, linkTick};

   ccsc_top #(.PLL_SET_CYC(HOLD)) u_dut (
      .core_clk(core_clk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
      .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .clockModePinLow(modeLow),
      .clockModePinHigh(1'b0), .nmiPin(nmi), .sleepReq(sleep),
      .linkClkTick(linkTick), .cpuClkTick(cpuTick), .cpuHold(cpuHold),
      .clkStopped(clkStop), .oscStopped(oscStop), .pllEnabled(pllOn));

   // *****************************
   // Helpers
   // *****************************
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         errorCnt++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One classic cycle; the note goes on the queue before the request
   task automatic acc(input logic chk, input logic we, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      int k;
      k = 0;
      expQ.push_back({chk, d});
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbSel <= s;
      wbDatI <= we ? d : 32'h0;
      do begin
         @(posedge core_clk);
         k++;
      end while (wbAck !== 1'b1 && k < 50);
      if (k >= 50) check(32'h0, 32'h1);
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      acc(1'b0, 1'b1, a, d, 4'hF);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      acc(1'b1, 1'b0, a, e, 4'hF);
   endtask

   // Interval between two ticks of the chosen divided clock
   task automatic period(input int cpu, output int p);
      int k;
      k = 0;
      p = 0;
      do @(posedge core_clk); while (ticks[cpu] !== 1'b1 && ++k < 300);
      do begin
         @(posedge core_clk);
         p++;
      end while (ticks[cpu] !== 1'b1 && p < 300);
   endtask

   // Standby round trip; wake time after the NMI edge must lie in l..h
   task automatic standby(input logic [31:0] cfg, input int l, input int h);
      int k;
      k = 0;
      wr(8'h44, cfg);
      sleep <= 1'b1;
      @(posedge core_clk);
      sleep <= 1'b0;
      @(posedge core_clk);
      @(posedge core_clk);
      check({31'h0, clkStop}, 32'h1);
      check({31'h0, oscStop}, {31'h0, cfg[4]});
      nmi <= 1'b1;
      while (clkStop === 1'b1 && k < 9000) begin
         @(posedge core_clk);
         k++;
      end
      check({31'h0, k >= l && k <= h}, 32'h1);
      nmi <= 1'b0;
      repeat (4) @(posedge core_clk);
      rd(8'h44, cfg);
   endtask

   // Monitor: each ack takes the oldest note and compares read data
   always @(posedge core_clk) begin
      if (wbAck === 1'b1) begin
         if (expQ.size() == 0) check(32'h0, 32'h1);
         else begin
            note = expQ.pop_front();
            if (note[32]) check(wbDatO, note[31:0]);
         end
      end
   end

   task automatic complete_run;
      $display("Checks %0d mismatches %0d", samplesChecked, errorCnt);
      if (errorCnt == 0 && samplesChecked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // *****************************
   // Clock, watchdog, sequence
   // *****************************
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   initial begin
      repeat (60000) @(posedge core_clk);
      errorCnt++;
      complete_run;
   end

   initial begin
      {rst, wbCyc, wbStb, wbWe, modeLow, nmi, sleep} = 7'h40;
      {wbAdr, wbSel, wbDatI} = 44'h0;
      rnd = 16'h0001;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      rd(8'h18, 32'h80);
      rd(8'h44, 32'h0);
      rd(8'h00, 32'h07500000);
      rd(8'h24, 32'h4000);
      wr(8'h10, 32'hFFFFFFFF);
      rd(8'h10, 32'h0);
      wr(8'h18, 32'hFFFFFF72);
      rd(8'h18, 32'h02);
      wr(8'h44, 32'hFFFFFFFF);
      acc(1'b0, 1'b1, 8'h44, 32'h0, 4'h3);
      rd(8'h44, 32'hFF37);
      $display("Test registers done");
      for (int c = 0; c < 2; c++)
         for (int i = 0; i < 10; i++) begin
            if (c == 1 && i == 2) continue;
            if (c == 0) wr(8'h18, {28'h0, code[i]});
            else wr(8'h00, {8'h07, code[i], 20'h0});
            period(c, n);
            check(n, ratio[i]);
         end
      wr(8'h18, 32'h80);
      n = 0;
      repeat (40) begin
         @(posedge core_clk);
         if (linkTick !== 1'b0) n++;
      end
      check(n, 0);
      $display("Test dividers done");
      wr(8'h00, 32'h0F500000);
      check({31'h0, cpuHold}, 32'h1);
      repeat (HOLD + 4) @(posedge core_clk);
      check({31'h0, cpuHold}, 32'h0);
      wr(8'h24, 32'h0);
      check({31'h0, cpuHold}, 32'h1);
      repeat (HOLD + 4) @(posedge core_clk);
      check({31'h0, pllOn}, 32'h0);
      wr(8'h24, 32'h4000);
      repeat (HOLD + 4) @(posedge core_clk);
      $display("Test pll done");
      rnd = lfsr(rnd);
      wr(8'h20, {16'hFFFF, rnd} | 32'h80);
      rd(8'h20, 32'h80);
      for (int c = 0; c < 8; c++)
         standby({16'h0, 8'hFE, 5'h06, c[2:0]}, pre[c], 2 * pre[c] + 12);
      standby(32'h0010, 0, 8);
      standby(32'h0020, 0, 8);
      rnd = lfsr(rnd);
      lo = 256 - (240 + rnd[3:0]);
      standby({16'h0, 4'hF, rnd[3:0], 8'h30}, lo, lo + 8);
      $display("Test standby done");
      rst <= 1'b1;
      modeLow <= 1'b1;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      modeLow <= 1'b0;
      rd(8'h00, 32'h07000000);
      rd(8'h24, 32'h0);
      $display("Test mode pins done");
      complete_run;
   end
endmodule // ccsc_top_tb
`default_nettype wire
